// *** srcc_top.sv ***
// Register bank and path control of the sample-rate converters
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "srcc_params.svh"
module srcc_top (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [15:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [7:0] PATH_ACTIVE,
  output logic [3:0] LP_LOCK,
  output logic LOCK_GPIO
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [3:0] async_en_reg;
  srcc_pkg::srcc_rate_t async_conv_second_rate_reg;
  srcc_pkg::srcc_rate_t async_conv_first_rate_reg;
  logic [1:0] interp_en_reg;
  srcc_pkg::srcc_rate_t interp_conv_output_rate_reg;
  srcc_pkg::srcc_rate_t interp_conv_input_rate_reg;
  logic [1:0] decim_en_reg;
  srcc_pkg::srcc_rate_t decim_conv_output_rate_reg;
  srcc_pkg::srcc_rate_t decim_conv_input_rate_reg;
  logic [7:0] budget_main_reg;
  logic [7:0] budget_sec_reg;
  logic [2:0] pin_sel_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  srcc_path_if pif ();

  logic wr_async_en;
  logic wr_async_ctl;
  logic wr_interp_en;
  logic wr_interp_ctl;
  logic wr_decim_en;
  logic wr_decim_ctl;
  logic wr_budget;
  logic wr_pin_sel;

  assign wr_async_en = REG_WR && (REG_ADDR == `SRCC_OFS_ASYNC_EN);
  assign wr_async_ctl = REG_WR && (REG_ADDR == `SRCC_OFS_ASYNC_CTL);
  assign wr_interp_en = REG_WR && (REG_ADDR == `SRCC_OFS_INTERP_EN);
  assign wr_interp_ctl = REG_WR && (REG_ADDR == `SRCC_OFS_INTERP_CTL);
  assign wr_decim_en = REG_WR && (REG_ADDR == `SRCC_OFS_DECIM_EN);
  assign wr_decim_ctl = REG_WR && (REG_ADDR == `SRCC_OFS_DECIM_CTL);
  assign wr_budget = REG_WR && (REG_ADDR == `SRCC_OFS_BUDGET);
  assign wr_pin_sel = REG_WR && (REG_ADDR == `SRCC_OFS_PIN_SEL);

  // Places a rate pair in its two fields
  function automatic logic [31:0] srcc_ctl_word(input srcc_pkg::srcc_rate_t hi, input srcc_pkg::srcc_rate_t lo);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SRCC_HI_RATE_MSB:`SRCC_HI_RATE_LSB] = hi;
    w[`SRCC_LO_RATE_MSB:`SRCC_LO_RATE_LSB] = lo;
    return w;
  endfunction : srcc_ctl_word

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous converter

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      async_en_reg <= 4'h0;
    end else if (wr_async_en) begin
      async_en_reg <= REG_WDATA[3:0];
    end
  end

  // Rate codes are stored as written; legality and ordering are software's duty
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      async_conv_second_rate_reg <= `SRCC_ASYNC_R2_RST;
      async_conv_first_rate_reg <= `SRCC_ASYNC_R1_RST;
    end else if (wr_async_ctl) begin
      async_conv_second_rate_reg <= REG_WDATA[`SRCC_HI_RATE_MSB:`SRCC_HI_RATE_LSB];
      async_conv_first_rate_reg <= REG_WDATA[`SRCC_LO_RATE_MSB:`SRCC_LO_RATE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power converters

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      interp_en_reg <= 2'h0;
    end else if (wr_interp_en) begin
      interp_en_reg <= REG_WDATA[1:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      interp_conv_output_rate_reg <= `SRCC_LP_RATE_RST;
      interp_conv_input_rate_reg <= `SRCC_LP_RATE_RST;
    end else if (wr_interp_ctl) begin
      interp_conv_output_rate_reg <= REG_WDATA[`SRCC_HI_RATE_MSB:`SRCC_HI_RATE_LSB];
      interp_conv_input_rate_reg <= REG_WDATA[`SRCC_LO_RATE_MSB:`SRCC_LO_RATE_LSB];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      decim_en_reg <= 2'h0;
    end else if (wr_decim_en) begin
      decim_en_reg <= REG_WDATA[1:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      decim_conv_output_rate_reg <= `SRCC_LP_RATE_RST;
      decim_conv_input_rate_reg <= `SRCC_LP_RATE_RST;
    end else if (wr_decim_ctl) begin
      decim_conv_output_rate_reg <= REG_WDATA[`SRCC_HI_RATE_MSB:`SRCC_HI_RATE_LSB];
      decim_conv_input_rate_reg <= REG_WDATA[`SRCC_LO_RATE_MSB:`SRCC_LO_RATE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock budget and lock pin select

  // Budget is paths per domain the clock can carry; zero refuses every new path on that domain
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      budget_main_reg <= `SRCC_BUDGET_RST;
      budget_sec_reg <= `SRCC_BUDGET_RST;
    end else if (wr_budget) begin
      budget_main_reg <= REG_WDATA[7:0];
      budget_sec_reg <= REG_WDATA[15:8];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pin_sel_reg <= `SRCC_PIN_SEL_RST;
    end else if (wr_pin_sel) begin
      pin_sel_reg <= REG_WDATA[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Path requests and domain use

  logic async_main;
  logic async_sec;
  logic interp_main;
  logic interp_sec;
  logic decim_main;
  logic decim_sec;

  // A path loads every domain that either of its rates lives on
  always_comb begin
    async_sec = srcc_pkg::srcc_on_second(async_conv_first_rate_reg)
      || srcc_pkg::srcc_on_second(async_conv_second_rate_reg);
    async_main = !srcc_pkg::srcc_on_second(async_conv_first_rate_reg)
      || !srcc_pkg::srcc_on_second(async_conv_second_rate_reg);
    interp_sec = srcc_pkg::srcc_on_second(interp_conv_input_rate_reg)
      || srcc_pkg::srcc_on_second(interp_conv_output_rate_reg);
    interp_main = !srcc_pkg::srcc_on_second(interp_conv_input_rate_reg)
      || !srcc_pkg::srcc_on_second(interp_conv_output_rate_reg);
    decim_sec = srcc_pkg::srcc_on_second(decim_conv_input_rate_reg)
      || srcc_pkg::srcc_on_second(decim_conv_output_rate_reg);
    decim_main = !srcc_pkg::srcc_on_second(decim_conv_input_rate_reg)
      || !srcc_pkg::srcc_on_second(decim_conv_output_rate_reg);
  end

  assign pif.req = {decim_en_reg, interp_en_reg, async_en_reg};
  assign pif.use_main = {{2{decim_main}}, {2{interp_main}}, {4{async_main}}};
  assign pif.use_sec = {{2{decim_sec}}, {2{interp_sec}}, {4{async_sec}}};
  assign pif.budget_main = budget_main_reg;
  assign pif.budget_sec = budget_sec_reg;

  srcc_admit u_admit (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .pif(pif.admit)
  );

  srcc_lock u_lock (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .pin_sel(pin_sel_reg),
    .pif(pif.view),
    .lock(LP_LOCK),
    .lock_pin(LOCK_GPIO)
  );

  assign PATH_ACTIVE = pif.active;

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `SRCC_OFS_ASYNC_EN: rdata_next = {28'h0000000, async_en_reg};
        `SRCC_OFS_ASYNC_STS: rdata_next = {28'h0000000, pif.active[3:0]};
        `SRCC_OFS_ASYNC_CTL: rdata_next = srcc_ctl_word(async_conv_second_rate_reg, async_conv_first_rate_reg);
        `SRCC_OFS_BUDGET: rdata_next = {16'h0000, budget_sec_reg, budget_main_reg};
        `SRCC_OFS_REFUSED: rdata_next = {24'h000000, pif.refused};
        `SRCC_OFS_PIN_SEL: rdata_next = {29'h00000000, pin_sel_reg};
        `SRCC_OFS_INTERP_EN: rdata_next = {30'h00000000, interp_en_reg};
        `SRCC_OFS_INTERP_CTL: rdata_next = srcc_ctl_word(interp_conv_output_rate_reg, interp_conv_input_rate_reg);
        `SRCC_OFS_DECIM_EN: rdata_next = {30'h00000000, decim_en_reg};
        `SRCC_OFS_DECIM_CTL: rdata_next = srcc_ctl_word(decim_conv_output_rate_reg, decim_conv_input_rate_reg);
        `SRCC_OFS_MIX_STS: rdata_next = {28'h0000000, pif.active[7:4]};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

endmodule : srcc_top
`default_nettype wire

// *** srcc_params.svh ***
// Offsets, field positions and reset values of the rate converter control block
//
// Notes on behaviour
// - Async enable bits: 2 rev right, 1 fwd left, 0 fwd right; reset zero.
// - Read-only status shows bits 3..0 of async paths really enabled; reset zero.
// - Async control: second rate 31:27 reset 0x08, first rate 15:11 reset 0x00.
// - Enable refused when domain clock budget too small; running paths keep running.
// - Mixer status shows which low-power paths really got enabled.
// - Low-power lock reported as soon as the path runs; feeds interrupt logic. Here lock follows one cycle after run; no interrupt logic.
// - Any low-power path lock can drive the lock pin.
// - Interpolator enable: bit 1 left, bit 0 right; reset zero.
// - Interpolator control: output rate 31:27, input rate 15:11, both reset 0x08.
// - Decimator enable bit 1 runs the left path; reset zero.
// - Decimator enable bit 0 runs the right path; reset zero.
// - Decimator control at 0xA108: output 31:27, input 15:11, both reset 0x08.
// - Async enable bit 3 runs the reverse left path; reset zero.
`ifndef SRCC_PARAMS_SVH
`define SRCC_PARAMS_SVH

`define SRCC_OFS_ASYNC_EN 16'hA000
`define SRCC_OFS_ASYNC_STS 16'hA004
`define SRCC_OFS_ASYNC_CTL 16'hA008
`define SRCC_OFS_BUDGET 16'hA010
`define SRCC_OFS_REFUSED 16'hA014
`define SRCC_OFS_PIN_SEL 16'hA018
`define SRCC_OFS_INTERP_EN 16'hA080
`define SRCC_OFS_INTERP_CTL 16'hA088
`define SRCC_OFS_DECIM_EN 16'hA0A8
`define SRCC_OFS_DECIM_CTL 16'hA108
`define SRCC_OFS_MIX_STS 16'h88C0

`define SRCC_HI_RATE_MSB 31
`define SRCC_HI_RATE_LSB 27
`define SRCC_LO_RATE_MSB 15
`define SRCC_LO_RATE_LSB 11

`define SRCC_ASYNC_R2_RST 5'h08
`define SRCC_ASYNC_R1_RST 5'h00
`define SRCC_LP_RATE_RST 5'h08
`define SRCC_BUDGET_RST 8'h08
`define SRCC_PIN_SEL_RST 3'h0

`endif

// *** srcc_pkg.sv ***
// Types and shared decoding for the rate converter control block
`default_nettype none
package srcc_pkg;

  typedef logic [4:0] srcc_rate_t;
  typedef logic [7:0] srcc_path_t;
  typedef logic [3:0] srcc_load_t;

  // Codes 0x08 and 0x09 run on the second domain clock
  function automatic logic srcc_on_second(input srcc_rate_t code);
    return (code == 5'h08) || (code == 5'h09);
  endfunction : srcc_on_second

  function automatic srcc_load_t srcc_count(input srcc_path_t v);
    srcc_load_t n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : srcc_count

endpackage : srcc_pkg
`default_nettype wire

// *** srcc_path_if.sv ***
// Path requests, domain use, budgets and admission results
`timescale 1ns/100ps
`default_nettype none
interface srcc_path_if;
  srcc_pkg::srcc_path_t req;
  srcc_pkg::srcc_path_t use_main;
  srcc_pkg::srcc_path_t use_sec;
  logic [7:0] budget_main;
  logic [7:0] budget_sec;
  srcc_pkg::srcc_path_t active;
  srcc_pkg::srcc_path_t refused;

  modport ctrl (output req, use_main, use_sec, budget_main, budget_sec, input active, refused);
  modport admit (input req, use_main, use_sec, budget_main, budget_sec, output active, refused);
  modport view (input active);
endinterface : srcc_path_if
`default_nettype wire

// *** srcc_admit.sv ***
// Clock-budget admission of converter path enables
`timescale 1ns/100ps
`default_nettype none
module srcc_admit (
  input wire logic clk,
  input wire logic rstn,
  srcc_path_if.admit pif
);

  srcc_pkg::srcc_path_t active_reg;
  srcc_pkg::srcc_path_t refused_reg;
  srcc_pkg::srcc_path_t pending;
  srcc_pkg::srcc_path_t pick;
  srcc_pkg::srcc_load_t load_main;
  srcc_pkg::srcc_load_t load_sec;
  logic fits;

  // One new path per cycle, lowest index first, so load counts stay exact
  always_comb begin
    pending = pif.req & ~active_reg & ~refused_reg;
    pick = pending & (~pending + 8'h01);
    load_main = srcc_pkg::srcc_count(active_reg & pif.use_main);
    load_sec = srcc_pkg::srcc_count(active_reg & pif.use_sec);
    fits = 1'b1;
    if (|(pick & pif.use_main) && ({4'h0, load_main} >= pif.budget_main)) begin
      fits = 1'b0;
    end
    if (|(pick & pif.use_sec) && ({4'h0, load_sec} >= pif.budget_sec)) begin
      fits = 1'b0;
    end
  end

  // Refused paths stay off until software drops and re-raises the enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_reg <= 8'h00;
    end else begin
      active_reg <= (active_reg | (fits ? pick : 8'h00)) & pif.req;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refused_reg <= 8'h00;
    end else begin
      refused_reg <= (refused_reg | (fits ? 8'h00 : pick)) & pif.req;
    end
  end

  assign pif.active = active_reg;
  assign pif.refused = refused_reg;

endmodule : srcc_admit
`default_nettype wire

// *** srcc_lock.sv ***
// Low-power converter lock status and lock pin selection
`timescale 1ns/100ps
`default_nettype none
module srcc_lock (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] pin_sel,
  srcc_path_if.view pif,
  output logic [3:0] lock,
  output logic lock_pin
);

  logic [3:0] lock_reg;
  logic pin_reg;
  logic [3:0] lp_active;

  assign lp_active = pif.active[7:4];

  // Both sides share one clock source, so lock follows run one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_reg <= 4'h0;
    end else begin
      lock_reg <= lp_active;
    end
  end

  // Select 0 parks the pin low; 1 to 4 pick a low-power path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_reg <= 1'b0;
    end else if (pin_sel >= 3'h1 && pin_sel <= 3'h4) begin
      pin_reg <= lp_active[pin_sel[1:0] - 2'h1];
    end else begin
      pin_reg <= 1'b0;
    end
  end

  assign lock = lock_reg;
  assign lock_pin = pin_reg;

endmodule : srcc_lock
`default_nettype wire

// *** srcc_top_chk.sv ***
// Port-level assertions for the rate converter control block
`timescale 1ns/100ps
`default_nettype none
module srcc_chk (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [15:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [7:0] PATH_ACTIVE,
  input wire logic [3:0] LP_LOCK,
  input wire logic LOCK_GPIO
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  logic en_wr;
  logic [3:0] since_wr_reg;
  assign en_wr = REG_WR && (REG_ADDR == 16'hA000 || REG_ADDR == 16'hA080 || REG_ADDR == 16'hA0A8);
  // Saturates so no path may rise long after the last enable write
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      since_wr_reg <= 4'hF;
    end else if (en_wr) begin
      since_wr_reg <= 4'h0;
    end else if (since_wr_reg != 4'hF) begin
      since_wr_reg <= since_wr_reg + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_lock;
    1'b1 |=> LP_LOCK == $past(PATH_ACTIVE[7:4]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock lags active");
  property p_gpio;
    LOCK_GPIO |-> LP_LOCK != 4'h0;
  endproperty
  a_gpio: assert property (p_gpio) else $error("lock pin without lock");
  property p_idle;
    !REG_RD |=> REG_RDATA == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_sts;
    REG_RD && REG_ADDR == 16'hA004 |=> REG_RDATA == {28'h0, $past(PATH_ACTIVE[3:0])};
  endproperty
  a_sts: assert property (p_sts) else $error("status mismatch");
  property p_mix;
    REG_RD && REG_ADDR == 16'h88C0 |=> REG_RDATA == {28'h0, $past(PATH_ACTIVE[7:4])};
  endproperty
  a_mix: assert property (p_mix) else $error("mixer status mismatch");
  property p_clr;
    REG_WR && REG_ADDR == 16'hA000 && !REG_WDATA[0] |-> ##2 !PATH_ACTIVE[0];
  endproperty
  a_clr: assert property (p_clr) else $error("path not cleared");
  property p_fall;
    |($past(PATH_ACTIVE) & ~PATH_ACTIVE) |-> $past(en_wr, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("active path dropped");
  property p_rise;
    |(PATH_ACTIVE & ~$past(PATH_ACTIVE)) |-> $onehot(PATH_ACTIVE & ~$past(PATH_ACTIVE))
      && since_wr_reg >= 4'h1 && since_wr_reg <= 4'h9;
  endproperty
  a_rise: assert property (p_rise) else $error("path rose unasked");
  property p_rst;
    $rose(RSTN) |-> PATH_ACTIVE == 8'h00 && LP_LOCK == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("paths on after reset");
endmodule : srcc_chk
bind srcc_top srcc_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PATH_ACTIVE(PATH_ACTIVE), .LP_LOCK(LP_LOCK),
  .LOCK_GPIO(LOCK_GPIO));
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the rate converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] path_active;
  logic [3:0] lp_lock;
  logic lock_gpio;
  logic [31:0] rv;
  logic [3:0] exp4;
  int failures = 0;
  int comparisons = 0;
  logic [15:0] addrs [7] = '{16'hA000, 16'hA004, 16'hA008, 16'hA080, 16'hA088, 16'hA0A8, 16'hA108};
  logic [31:0] rsts [7] = '{32'h0, 32'h0, 32'h4000_0000, 32'h0, 32'h4000_4000, 32'h0, 32'h4000_4000};
  logic [15:0] ctls [3] = '{16'hA008, 16'hA088, 16'hA108};

  srcc_top dut (.CLK_SYS(clk_sys), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PATH_ACTIVE(path_active), .LP_LOCK(lp_lock), .LOCK_GPIO(lock_gpio));

  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data stands one cycle only, so sample it mid-cycle
  task automatic chk_rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask : chk_rd

  // Room for one admission per cycle before anything is looked at
  task automatic wen(input logic [15:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wen
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) chk_rd(addrs[i], rsts[i]);
    // Reset rates put async paths on both domains; second-domain budget of one path
    wr(16'hA010, 32'h0000_0108);
    wen(16'hA000, 32'h3);
    chk_rd(16'hA004, 32'h1);
    chk_rd(16'hA014, 32'h2);
    wen(16'hA000, 32'h0);
    wr(16'hA010, 32'h0000_0808);
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 4; c++) begin
        rv = {5'(c), 11'h0, 5'(3 - c), 11'h0};
        wr(ctls[i], rv);
        chk_rd(ctls[i], rv);
      end
    end
    wen(16'hA000, 32'hF);
    chk({24'h0, path_active}, 32'h0F);
    for (int i = 0; i < 4; i++) begin
      wen(16'hA000, 32'h1 << i);
      chk_rd(16'hA004, 32'h1 << i);
    end
    // Main budget of one path: second enable must be refused
    wen(16'hA000, 32'h0);
    wr(16'hA010, 32'h0000_0801);
    wen(16'hA000, 32'h3);
    chk_rd(16'hA004, 32'h1);
    chk_rd(16'hA014, 32'h2);
    wen(16'hA010, 32'h0);
    chk_rd(16'hA004, 32'h1);
    wen(16'hA010, 32'h0000_0808);
    chk_rd(16'hA004, 32'h1);
    wr(16'hA004, 32'hF);
    chk_rd(16'hA004, 32'h1);
    chk_rd(16'hA00C, 32'h0);
    wen(16'hA000, 32'h0);
    chk_rd(16'hA014, 32'h0);
    for (int p = 0; p < 2; p++) begin
      wen(16'hA080, p ? 32'h2 : 32'h1);
      wen(16'hA0A8, p ? 32'h1 : 32'h2);
      exp4 = p ? 4'b0110 : 4'b1001;
      chk({28'h0, lp_lock}, {28'h0, exp4});
      chk_rd(16'h88C0, {28'h0, exp4});
      for (int s = 0; s < 6; s++) begin
        wr(16'hA018, 32'(s));
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, lock_gpio}, 32'((s >= 1 && s <= 4) && exp4[(s + 3) % 4]));
      end
    end
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({24'h0, path_active}, 32'h0);
    rstn <= 1'b1;
    chk_rd(16'hA080, 32'h0);
    final_report;
  end

  // The sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    final_report;
  end
endmodule : tb_top
`default_nettype wire
